// ---- logic/tpwc_regs.vh ----
`ifndef TPWC_REGS_VH
`define TPWC_REGS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TPWC_OFS_CTL0 8'h00
`define TPWC_OFS_CTL1 8'h04
`define TPWC_OFS_OPT0 8'h08
`define TPWC_OFS_IOC0 8'h0C
`define TPWC_OFS_IOC1 8'h10
`define TPWC_OFS_CCR0 8'h14
`define TPWC_OFS_CCR1 8'h18
`define TPWC_OFS_CNT 8'h1C
`define TPWC_OFS_OVFCLR 8'h20
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TPWC_CTL0_CE 0
`define TPWC_CTL1_MD_HI 2
`define TPWC_CTL1_MD_LO 0
`define TPWC_CTL1_CKS_HI 6
`define TPWC_CTL1_CKS_LO 4
`define TPWC_CTL1_SYE 7
`define TPWC_OPT0_OVF 0
`define TPWC_OPT0_CCS0 1
`define TPWC_OPT0_CCS1 2
`define TPWC_IOC0_OE0 0
`define TPWC_IOC0_OL0 1
`define TPWC_IOC0_OE1 2
`define TPWC_IOC0_OL1 3
`define TPWC_IOC1_IS0_HI 1
`define TPWC_IOC1_IS0_LO 0
`define TPWC_IOC1_IS1_HI 3
`define TPWC_IOC1_IS1_LO 2
`define TPWC_OVFCLR_BIT 0
// ----------------------------------------
// Modes, clock selects, edge selects
// ----------------------------------------
`define TPWC_MD_INTERVAL 3'h0
`define TPWC_MD_EVENT 3'h1
`define TPWC_MD_TRIGGER 3'h2
`define TPWC_MD_ONESHOT 3'h3
`define TPWC_MD_PWM 3'h4
`define TPWC_MD_FREERUN 3'h5
`define TPWC_MD_PWMEAS 3'h6
`define TPWC_CKS_EXT 3'h7
`define TPWC_EDGE_NONE 2'h0
`define TPWC_EDGE_RISE 2'h1
`define TPWC_EDGE_FALL 2'h2
`define TPWC_EDGE_BOTH 2'h3
// ----------------------------------------
// Values
// ----------------------------------------
`define TPWC_CNT_MAX 16'hFFFF
`define TPWC_CNT_ZERO 16'h0000
`define TPWC_PRE_ONES 7'h7F
`define TPWC_REG_RST 8'h00
`define TPWC_WORD_RST 32'h00000000
`define TPWC_HTRANS_NONSEQ 1'b1
`define TPWC_ADDR_LSB 2
`define TPWC_ADDR_HI 7
`endif

// ---- logic/tpwc_timer.v ----
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
`include "tpwc_regs.vh"

// Overview of operation
// [RULE1] Mode 110 measures; count enable starts counter
// [RULE2] Valid edge copies count, clears counter
// [RULE3] Each capture pulses its capture interrupt
// [RULE4] Software uses one input, other edge none
// [RULE5] External clock on input 0, measure input 1
// [RULE6] Past FFFFH: overflow interrupt, wrap, continue
// [RULE7] Overflow sets sticky flag until cleared
// [RULE8] Software adds overflows times 10000H
// [RULE9] Bit clear or option write clears flag; the code clears on an OPT0 write only when OVF is written 0
// [RULE10] Software reads flag before clearing it
// [RULE11] Overflow set beats coincident clear
// [RULE12] Output square wave per mode, none measuring; the code toggles the outputs only in interval, event and free-running modes
// [RULE13] Level 0: low idle, high when counting
// [RULE14] Level 1: high idle, low when counting
// [RULE15] Tuned slave extends fixed master timer
// [RULE16] Tuning only in PWM and free-running
// [RULE17] Compare buffer: write or match transfer
// [RULE18] Tuned slave overflow flag, interrupt held low
// [RULE19] Tuned slave starts with master enable
// [RULE20] Capture edges synchronised, one capture each
// [RULE21] Capture and overflow together both happen
module tpwc_timer (
  input wire clk_in, // 20 MHz clock
  input wire rst_n_in, // Synchronous reset, active low
  input wire hsel_in, // AHB slave select
  input wire [31:0] haddr_in, // AHB address
  input wire [1:0] htrans_in, // AHB transfer type
  input wire hwrite_in, // AHB write
  input wire [2:0] hsize_in, // AHB size
  input wire [31:0] hwdata_in, // AHB write data
  input wire hready_in, // AHB bus ready
  output reg [31:0] hrdata_out, // AHB read data
  output reg hreadyout_out, // AHB slave ready
  output reg hresp_out, // AHB response, always OKAY
  input wire capture_input_0_in, // Capture input 0 / external clock
  input wire capture_input_1_in, // Capture input 1
  input wire master_count_enable_in, // Tuned master count enable
  input wire master_tick_in, // Tuned master count clock pulse
  output reg count_enable_out, // Effective count enable
  output reg count_tick_out, // Count clock pulse for a slave
  output reg timer_output_0_out, // Timer output pin 0
  output reg timer_output_1_out, // Timer output pin 1
  output reg capture_irq_0_out, // Capture/compare 0 interrupt pulse
  output reg capture_irq_1_out, // Capture/compare 1 interrupt pulse
  output reg overflow_irq_out // Overflow interrupt pulse
);

  localparam ST_ADDR = 2'b01;
  localparam ST_DATA = 2'b10;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function edge_hit;
    input [1:0] sel;
    input prev;
    input cur;
    begin
      case (sel)
        `TPWC_EDGE_RISE: edge_hit = ~prev & cur;
        `TPWC_EDGE_FALL: edge_hit = prev & ~cur;
        `TPWC_EDGE_BOTH: edge_hit = prev ^ cur;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  function div_hit;
    input [6:0] pre;
    input [2:0] cks;
    reg [6:0] mask;
    begin
      mask = ~(`TPWC_PRE_ONES << cks);
      div_hit = ((pre & mask) == mask);
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [1:0] bus_state_reg;
  reg [7:0] addr_reg;
  reg write_reg;
  reg [7:0] ctl0_reg;
  reg [7:0] ctl1_reg;
  reg [2:0] ccs_reg;
  reg overflow_flag_reg;
  reg [7:0] ioc0_reg;
  reg [7:0] ioc1_reg;
  reg [15:0] ccr0_reg;
  reg [15:0] ccr1_reg;
  reg [15:0] cmp0_reg;
  reg [15:0] cmp1_reg;
  reg [15:0] cnt_reg;
  reg [6:0] pre_reg;
  reg in0_s1_reg, in0_s2_reg, in0_s3_reg;
  reg in1_s1_reg, in1_s2_reg, in1_s3_reg;
  reg pend0_reg;
  reg pend1_reg;
  reg tog0_reg;
  reg tog1_reg;
  reg [31:0] rdata_next;

  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  wire [2:0] mode = ctl1_reg[`TPWC_CTL1_MD_HI:`TPWC_CTL1_MD_LO];
  wire [2:0] cks = ctl1_reg[`TPWC_CTL1_CKS_HI:`TPWC_CTL1_CKS_LO];
  wire is_pwmeas = (mode == `TPWC_MD_PWMEAS);
  wire is_freerun = (mode == `TPWC_MD_FREERUN);
  wire is_interval = (mode == `TPWC_MD_INTERVAL) | (mode == `TPWC_MD_EVENT);
  // Tuning is honoured only in the two modes that support it
  wire tuned = ctl1_reg[`TPWC_CTL1_SYE] & (is_freerun | (mode == `TPWC_MD_PWM)); // [RULE16]
  wire ce_eff = tuned ? master_count_enable_in : ctl0_reg[`TPWC_CTL0_CE]; // [RULE1] [RULE19]
  wire ext_rise = ~in0_s3_reg & in0_s2_reg;
  wire tick_raw = tuned ? master_tick_in :
                  (cks == `TPWC_CKS_EXT) ? ext_rise : div_hit(pre_reg, cks); // [RULE15]
  wire tick = ce_eff & tick_raw;
  wire edge0 = edge_hit(ioc1_reg[`TPWC_IOC1_IS0_HI:`TPWC_IOC1_IS0_LO], in0_s3_reg, in0_s2_reg); // [RULE20]
  wire edge1 = edge_hit(ioc1_reg[`TPWC_IOC1_IS1_HI:`TPWC_IOC1_IS1_LO], in1_s3_reg, in1_s2_reg); // [RULE20]
  wire cap_en0 = is_pwmeas | (is_freerun & ccs_reg[0]);
  wire cap_en1 = is_pwmeas | (is_freerun & ccs_reg[1]);
  wire cap0 = tick & cap_en0 & pend0_reg;
  wire cap1 = tick & cap_en1 & pend1_reg;
  wire match0 = tick & ~cap_en0 & (cnt_reg == cmp0_reg);
  wire match1 = tick & ~cap_en1 & (cnt_reg == cmp1_reg);
  wire clr_cnt = (is_pwmeas & (cap0 | cap1)) | (is_interval & match0); // [RULE2]
  // A slave in tuned operation never reports its own overflow
  wire ovf_event = tick & (cnt_reg == `TPWC_CNT_MAX) & ~tuned & ~(is_interval & match0); // [RULE6] [RULE18]

  wire bus_acc = hsel_in & htrans_in[1] & hready_in & bus_state_reg[0];
  wire wr_now = bus_state_reg[1] & write_reg;
  wire wr_opt0 = wr_now & (addr_reg == `TPWC_OFS_OPT0);
  wire ovf_clr = (wr_opt0 & ~hwdata_in[`TPWC_OPT0_OVF]) |
                 (wr_now & (addr_reg == `TPWC_OFS_OVFCLR) & hwdata_in[`TPWC_OVFCLR_BIT]); // [RULE9]
  wire wr_ccr0 = wr_now & (addr_reg == `TPWC_OFS_CCR0);
  wire wr_ccr1 = wr_now & (addr_reg == `TPWC_OFS_CCR1);
  wire out0_act = ioc0_reg[`TPWC_IOC0_OE0] & ce_eff;
  wire out1_act = ioc0_reg[`TPWC_IOC0_OE1] & ce_eff;

  // ----------------------------------------
  // AHB-Lite slave, one wait state per access
  // ----------------------------------------
  always @* begin
    case (addr_reg)
      `TPWC_OFS_CTL0: rdata_next = {24'h000000, ctl0_reg};
      `TPWC_OFS_CTL1: rdata_next = {24'h000000, ctl1_reg};
      `TPWC_OFS_OPT0: rdata_next = {29'h00000000, ccs_reg[1:0], overflow_flag_reg};
      `TPWC_OFS_IOC0: rdata_next = {24'h000000, ioc0_reg};
      `TPWC_OFS_IOC1: rdata_next = {24'h000000, ioc1_reg};
      `TPWC_OFS_CCR0: rdata_next = {16'h0000, ccr0_reg};
      `TPWC_OFS_CCR1: rdata_next = {16'h0000, ccr1_reg};
      `TPWC_OFS_CNT: rdata_next = {16'h0000, cnt_reg};
      default: rdata_next = `TPWC_WORD_RST;
    endcase
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      bus_state_reg <= ST_ADDR;
      addr_reg <= `TPWC_REG_RST;
      write_reg <= 1'b0;
      hrdata_out <= `TPWC_WORD_RST;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      hresp_out <= 1'b0;
      case (bus_state_reg)
        ST_ADDR: begin
          if (bus_acc) begin
            addr_reg <= {haddr_in[`TPWC_ADDR_HI:`TPWC_ADDR_LSB], 2'b00};
            write_reg <= hwrite_in;
            hreadyout_out <= 1'b0;
            bus_state_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (!write_reg) begin
            hrdata_out <= rdata_next;
          end
          hreadyout_out <= 1'b1;
          bus_state_reg <= ST_ADDR;
        end
        default: begin
          hreadyout_out <= 1'b1;
          bus_state_reg <= ST_ADDR;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctl0_reg <= `TPWC_REG_RST;
      ctl1_reg <= `TPWC_REG_RST;
      ccs_reg <= 3'h0;
      ioc0_reg <= `TPWC_REG_RST;
      ioc1_reg <= `TPWC_REG_RST;
    end else if (wr_now) begin
      case (addr_reg)
        `TPWC_OFS_CTL0: ctl0_reg <= hwdata_in[7:0];
        `TPWC_OFS_CTL1: ctl1_reg <= hwdata_in[7:0];
        `TPWC_OFS_OPT0: ccs_reg <= {1'b0, hwdata_in[`TPWC_OPT0_CCS1], hwdata_in[`TPWC_OPT0_CCS0]};
        `TPWC_OFS_IOC0: ioc0_reg <= hwdata_in[7:0];
        `TPWC_OFS_IOC1: ioc1_reg <= hwdata_in[7:0];
        default: ctl0_reg <= ctl0_reg;
      endcase
    end
  end

  // ----------------------------------------
  // Input synchronisers and edge pending
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      in0_s1_reg <= 1'b0;
      in0_s2_reg <= 1'b0;
      in0_s3_reg <= 1'b0;
      in1_s1_reg <= 1'b0;
      in1_s2_reg <= 1'b0;
      in1_s3_reg <= 1'b0;
      pend0_reg <= 1'b0;
      pend1_reg <= 1'b0;
      pre_reg <= 7'h00;
    end else begin
      in0_s1_reg <= capture_input_0_in;
      in0_s2_reg <= in0_s1_reg;
      in0_s3_reg <= in0_s2_reg;
      in1_s1_reg <= capture_input_1_in;
      in1_s2_reg <= in1_s1_reg;
      in1_s3_reg <= in1_s2_reg;
      pre_reg <= ce_eff ? pre_reg + 7'h01 : 7'h00;
      // Edge held until next count clock, so one capture per edge
      pend0_reg <= ce_eff & ((pend0_reg & ~tick) | edge0); // [RULE20]
      pend1_reg <= ce_eff & ((pend1_reg & ~tick) | edge1); // [RULE20]
    end
  end

  // ----------------------------------------
  // Counter, capture, compare, overflow
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_reg <= `TPWC_CNT_ZERO;
      ccr0_reg <= `TPWC_CNT_ZERO;
      ccr1_reg <= `TPWC_CNT_ZERO;
      cmp0_reg <= `TPWC_CNT_ZERO;
      cmp1_reg <= `TPWC_CNT_ZERO;
      overflow_flag_reg <= 1'b0;
      tog0_reg <= 1'b0;
      tog1_reg <= 1'b0;
      capture_irq_0_out <= 1'b0;
      capture_irq_1_out <= 1'b0;
      overflow_irq_out <= 1'b0;
    end else begin
      if (!ce_eff) begin
        cnt_reg <= `TPWC_CNT_ZERO;
        tog0_reg <= 1'b0;
        tog1_reg <= 1'b0;
      end else if (tick) begin
        cnt_reg <= clr_cnt ? `TPWC_CNT_ZERO : cnt_reg + 16'h0001; // [RULE2] [RULE6] [RULE21]
        tog0_reg <= tog0_reg ^ ((is_interval | is_freerun) & match0); // [RULE12]
        tog1_reg <= tog1_reg ^ ((is_interval & match0) | (is_freerun & match1)); // [RULE12]
      end
      // Captures win over bus writes to the same register
      if (cap0) begin
        ccr0_reg <= cnt_reg; // [RULE2]
      end else if (wr_ccr0) begin
        ccr0_reg <= hwdata_in[15:0];
      end
      if (cap1) begin
        ccr1_reg <= cnt_reg; // [RULE2]
      end else if (wr_ccr1) begin
        ccr1_reg <= hwdata_in[15:0];
      end
      // Every mode loads the compare while stopped or at match; free-running mode also loads it at write
      if (!ce_eff | (is_freerun & wr_ccr0) | match0) begin
        cmp0_reg <= wr_ccr0 ? hwdata_in[15:0] : ccr0_reg; // [RULE17]
      end
      if (!ce_eff | (is_freerun & wr_ccr1) | match1) begin
        cmp1_reg <= wr_ccr1 ? hwdata_in[15:0] : ccr1_reg; // [RULE17]
      end
      capture_irq_0_out <= cap0 | match0; // [RULE3]
      capture_irq_1_out <= cap1 | match1; // [RULE3]
      overflow_irq_out <= ovf_event; // [RULE6]
      if (tuned) begin
        overflow_flag_reg <= 1'b0; // [RULE18]
      end else if (ovf_event) begin
        overflow_flag_reg <= 1'b1; // [RULE7] [RULE11] [RULE21]
      end else if (ovf_clr) begin
        overflow_flag_reg <= 1'b0; // [RULE9]
      end
    end
  end

  // ----------------------------------------
  // Output pins
  // ----------------------------------------
  // Measuring mode never toggles, so pins sit at their start level
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      timer_output_0_out <= 1'b0;
      timer_output_1_out <= 1'b0;
      count_enable_out <= 1'b0;
      count_tick_out <= 1'b0;
    end else begin
      timer_output_0_out <= ioc0_reg[`TPWC_IOC0_OL0] ^ (out0_act & ~tog0_reg); // [RULE13] [RULE14]
      timer_output_1_out <= ioc0_reg[`TPWC_IOC0_OL1] ^ (out1_act & ~tog1_reg); // [RULE13] [RULE14] [RULE12]
      count_enable_out <= ce_eff;
      count_tick_out <= tick;
    end
  end

endmodule

// ---- tb/tpwc_timer_chk.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module tpwc_timer_chk (
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Reset
  input wire logic hsel_in, // Select
  input wire logic [1:0] htrans_in, // Transfer type
  input wire logic hready_in, // Bus ready
  input wire logic [31:0] hrdata_out, // Read data
  input wire logic hreadyout_out, // Slave ready
  input wire logic hresp_out, // Response
  input wire logic capture_input_1_in, // Capture input 1
  input wire logic capture_irq_1_out, // Capture irq 1
  input wire logic overflow_irq_out // Overflow irq
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [31:0] gap;
  logic seen;
  logic [7:0] since1;
  // Wraps must be a full 16-bit turn apart
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      gap <= 32'h0;
      seen <= 1'b0;
    end else if (overflow_irq_out) begin
      gap <= 32'h0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 32'h1;
    end
  end
  // Age of the last input change, saturating
  always @(posedge clk_in) begin
    if (!rst_n_in || $changed(capture_input_1_in)) begin
      since1 <= 8'h00;
    end else if (since1 != 8'hFF) begin
      since1 <= since1 + 8'h01;
    end
  end
  a_rdy_one_wait: assert property (hsel_in && htrans_in[1] && hready_in && hreadyout_out
    |=> !hreadyout_out ##1 hreadyout_out) else $error("wait state wrong");
  a_resp_okay: assert property (hresp_out == 1'b0) else $error("response not OKAY");
  // Reset itself is the antecedent, so the default disable must not mask it
  a_rst_outs: assert property (disable iff (1'b0) !rst_n_in |=> hreadyout_out && !overflow_irq_out && !capture_irq_1_out)
    else $error("reset outputs wrong");
  a_cap_pulse: assert property (capture_irq_1_out |=> !capture_irq_1_out) else $error("capture irq long");
  a_ovf_pulse: assert property (overflow_irq_out |=> !overflow_irq_out) else $error("overflow irq long");
  a_cap_synced: assert property ($rose(capture_irq_1_out) |-> since1 >= 8'h02 && since1 <= 8'hC8)
    else $error("capture irq without synced edge");
  a_ovf_gap: assert property (overflow_irq_out && seen |-> gap >= 32'h0000FFFF)
    else $error("overflow too early");
  a_rdata_hold: assert property ($changed(hrdata_out) |-> $rose(hreadyout_out)) else $error("read data moved");
endmodule

// ---- tb/tpwc_pulse_src.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// External pulse source
// ----------------------------------------
module tpwc_pulse_src (
  input wire logic clk_in, // Bench clock
  output logic cap0_out, // Capture input 0 level
  output logic cap1_out // Capture input 1 level
);
  // Input 0 held quiet: a single trigger input is used
  initial cap0_out = 1'b0;
  initial cap1_out = 1'b0;
  task automatic pulse(input int hi, input int lo);
    @(posedge clk_in);
    cap1_out <= 1'b1;
    repeat (hi) @(posedge clk_in);
    cap1_out <= 1'b0;
    repeat (lo) @(posedge clk_in);
  endtask
endmodule

// ---- tb/tpwc_timer_tb.sv ----
`timescale 1ns/10ps
`include "tpwc_regs.vh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tpwc_timer_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire [31:0] hrdata;
  wire hrdy;
  wire cap0;
  wire cap1;
  wire pin0;
  wire pin1;
  wire irq1;
  wire ovf_irq;
  wire irq0;
  wire ce_o;
  wire tk;
  logic m_en = 1'b0;
  int irq0_cnt = 0;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int irq1_cnt = 0;
  int ovf_cnt = 0;
  initial forever #25 clk_in = ~clk_in;
  tpwc_pulse_src u_tpwc_pulse_src (.clk_in(clk_in), .cap0_out(cap0), .cap1_out(cap1));
  tpwc_timer u_tpwc_timer (.clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(), .capture_input_0_in(cap0),
    .capture_input_1_in(cap1), .master_count_enable_in(m_en), .master_tick_in(1'b0),
    .count_enable_out(ce_o), .count_tick_out(tk), .timer_output_0_out(pin0), .timer_output_1_out(pin1),
    .capture_irq_0_out(irq0), .capture_irq_1_out(irq1), .overflow_irq_out(ovf_irq));
  // ----------------------------------------
  // Closing report
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Event counters and hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (irq1 === 1'b1) irq1_cnt <= irq1_cnt + 1;
    if (irq0 === 1'b1) irq0_cnt <= irq0_cnt + 1;
    if (ovf_irq === 1'b1) ovf_cnt <= ovf_cnt + 1;
    if (cyc == 90000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask
  // Pins lag their cause by a cycle
  task automatic pins(input logic e0, input logic e1);
    repeat (3) @(posedge clk_in);
    `CHK("pin0", e0, pin0)
    `CHK("pin1", e1, pin1)
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rdchk(`TPWC_OFS_CNT, 32'h0, "cnt_rst");
    rdchk(`TPWC_OFS_OPT0, 32'h0, "opt0_rst");
    rdchk(8'h3C, 32'h0, "unmapped");
    bus(1'b1, `TPWC_OFS_IOC1, 32'h4);
    bus(1'b1, `TPWC_OFS_CTL1, {29'h0, `TPWC_MD_PWMEAS});
    bus(1'b1, `TPWC_OFS_IOC0, 32'hD);
    pins(1'b0, 1'b1);
    bus(1'b1, `TPWC_OFS_CTL0, 32'h1);
    pins(1'b1, 1'b0);
    `CHK("tick_out", 1'b1, tk)
    // Rising edges 41 cycles apart: the count stands at 40 when captured
    repeat (2) u_tpwc_pulse_src.pulse(15, 25);
    rdchk(`TPWC_OFS_CCR1, 32'h28, "ccr1");
    `CHK("irq1_cnt", 2, irq1_cnt)
    `CHK("irq0_cnt", 0, irq0_cnt)
    pins(1'b1, 1'b0);
    for (int i = 0; i < 70000 && ovf_irq !== 1'b1; i++) @(posedge clk_in);
    @(posedge clk_in);
    `CHK("ovf_cnt", 1, ovf_cnt)
    rdchk(`TPWC_OFS_OPT0, 32'h1, "ovf_flag");
    bus(1'b0, `TPWC_OFS_CNT, 32'h0);
    `CHK("wrapped", 1'b1, rd < 32'h40)
    rdchk(`TPWC_OFS_CCR1, 32'h28, "ccr1_kept");
    bus(1'b1, `TPWC_OFS_OPT0, 32'h1);
    rdchk(`TPWC_OFS_OPT0, 32'h1, "flag_w1");
    bus(1'b1, `TPWC_OFS_OVFCLR, 32'h0);
    rdchk(`TPWC_OFS_OPT0, 32'h1, "flag_clr0");
    bus(1'b1, `TPWC_OFS_OVFCLR, 32'h1);
    rdchk(`TPWC_OFS_OPT0, 32'h0, "flag_clr1");
    bus(1'b1, `TPWC_OFS_CTL0, 32'h0);
    pins(1'b0, 1'b1);
    // Tuned slave: its own enable is ignored, the master's starts it
    bus(1'b1, `TPWC_OFS_CTL1, 32'h85);
    bus(1'b1, `TPWC_OFS_CTL0, 32'h1);
    pins(1'b0, 1'b1);
    `CHK("ce_off", 1'b0, ce_o)
    m_en <= 1'b1;
    pins(1'b1, 1'b0);
    `CHK("ce_on", 1'b1, ce_o)
    end_of_test();
  end
endmodule
bind tpwc_timer tpwc_timer_chk u_tpwc_timer_chk (.clk_in, .rst_n_in, .hsel_in, .htrans_in, .hready_in,
  .hrdata_out, .hreadyout_out, .hresp_out, .capture_input_1_in, .capture_irq_1_out, .overflow_irq_out);
